// ---- shared/hssp_regs.vh ----
// Constants and register map of the host serial slave port
//
// Contract
// - Stalled two-wire transaction aborted after timeout; never here: enable bit is only writable in serial mode
// - Host link setup enables watchdog, picks timeout
// - Serial transfers up to 20/50 Mbit/s
// - Default four wires: select, clock, in, out
// - Three-wire bit makes data input bidirectional
// - Read data shifts out one bit per clock
// - Select high ends; new address needed
// - Drive on falling edge, sample on rising
// - Addresses 0..3 each served by DMA channel
// - Channel 0 write-only commands; 1..3 read-only
// - Channels 1..3 deliver wakeup, nonwakeup, status
// - Reading past channel contents returns zeros
// - Command overflow discards whole session data
// - Other registers auto-increment after each byte
// - Two-wire after reset; select low locks serial
// - Every byte most significant bit first
`ifndef HSSP_REGS_VH
`define HSSP_REGS_VH

// ****************************************
// Register addresses
// ****************************************
`define HSSP_ADDR_CMD_CH 7'h00
`define HSSP_ADDR_WAKE_CH 7'h01
`define HSSP_ADDR_NWAKE_CH 7'h02
`define HSSP_ADDR_STAT_CH 7'h03
`define HSSP_ADDR_LINK_SETUP 7'h16
`define HSSP_ADDR_PORT_STATUS 7'h17
`define HSSP_ADDR_LAST 7'h3f

// ****************************************
// Field positions and reset values
// ****************************************
`define HSSP_LINK_THREE_WIRE 1
`define HSSP_LINK_WDT_EN 2
`define HSSP_LINK_WDT_LONG 3
`define HSSP_LINK_RESET 8'h00
`define HSSP_STAT_SERIAL 0
`define HSSP_STAT_OVERFLOW 1
`define HSSP_STAT_TWI_BUSY 2
`define HSSP_STAT_WDT_ABORT 3
`define HSSP_LAST_BIT 3'h7

// ****************************************
// Timing and sizes
// ****************************************
`define HSSP_CLK_MHZ 125
`define HSSP_WDT_SHORT_US 1000
`define HSSP_WDT_LONG_US 50000
`define HSSP_FIFO_WIDTH 8
`define HSSP_FIFO_DEPTH 16
`define HSSP_LEN_WIDTH 16

`endif

// ---- logic/hssp_fifo.v ----
// Command FIFO with session commit and discard
`timescale 1ns/1ps
module hssp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Filling side
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	// Session control
	input wire commit_in,
	input wire discard_in,
	// Draining side
	output reg out_valid_out,
	input wire out_ready_in,
	output reg [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_tmp;
	reg [AW:0] wr_com;
	reg [AW:0] rd_ptr;
	wire full;
	wire avail;
	wire take;

	// Full counts uncommitted words, so a session cannot overrun readers
	assign full = (wr_tmp[AW-1:0] == rd_ptr[AW-1:0]) &&
		(wr_tmp[AW] != rd_ptr[AW]);
	assign in_ready_out = ~full;
	// Only committed words become visible
	assign avail = (wr_com != rd_ptr);
	assign take = avail && (~out_valid_out || out_ready_in);

	// Storage write
	always @(posedge clk_in) begin
		if (in_valid_in && ~full) begin
			mem[wr_tmp[AW-1:0]] <= in_data_in;
		end
	end

	// Pointers and output stage
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_tmp <= {(AW+1){1'b0}};
			wr_com <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
			out_valid_out <= 1'b0;
			out_data_out <= {WIDTH{1'b0}};
		end else begin
			if (discard_in) begin
				wr_tmp <= wr_com;
			end else if (in_valid_in && ~full) begin
				wr_tmp <= wr_tmp + 1'b1;
			end
			if (commit_in) begin
				wr_com <= wr_tmp;
			end
			if (take) begin
				out_data_out <= mem[rd_ptr[AW-1:0]];
				out_valid_out <= 1'b1;
				rd_ptr <= rd_ptr + 1'b1;
			end else if (out_ready_in) begin
				out_valid_out <= 1'b0;
			end
		end
	end
endmodule // hssp_fifo

// ---- logic/hssp_twi_watchdog.v ----
// Stall watchdog for the two-wire protocol engine
`timescale 1ns/1ps
module hssp_twi_watchdog #(
	parameter SHORT_CYCLES = 125000,
	parameter LONG_CYCLES = 6250000
) (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Synchronised bus lines
	input wire scl_in,
	input wire sda_in,
	// Control
	input wire enable_in,
	input wire long_in,
	input wire engine_on_in,
	// State
	output reg busy_out,
	output reg abort_out
);
	reg scl_d;
	reg sda_d;
	reg [31:0] cnt;
	wire start_cond;
	wire stop_cond;
	wire activity;
	wire [31:0] limit;

	// Start and stop seen with clock high
	assign start_cond = scl_in && scl_d && sda_d && ~sda_in;
	assign stop_cond = scl_in && scl_d && ~sda_d && sda_in;
	assign activity = (scl_in != scl_d) || (sda_in != sda_d);
	assign limit = long_in ? LONG_CYCLES : SHORT_CYCLES;

	// Transaction tracking and timeout
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			busy_out <= 1'b0;
			abort_out <= 1'b0;
			cnt <= 32'h0000_0000;
		end else begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			abort_out <= 1'b0;
			if (~engine_on_in || stop_cond) begin
				busy_out <= 1'b0;
			end else if (start_cond) begin
				busy_out <= 1'b1;
			end
			if (~busy_out || activity) begin
				cnt <= 32'h0000_0000;
			end else if (enable_in) begin
				cnt <= cnt + 32'h0000_0001;
			end
			if (enable_in && busy_out && ~activity &&
				cnt >= limit - 32'h0000_0001) begin
				busy_out <= 1'b0;
				abort_out <= 1'b1;
				cnt <= 32'h0000_0000;
			end
		end
	end
endmodule // hssp_twi_watchdog

// ---- logic/hssp_top.v ----
// Host serial slave port: serial link, register file and DMA channels
`timescale 1ns/1ps
`include "hssp_regs.vh"
module hssp_top #(
	parameter WDT_SHORT_CYCLES = `HSSP_WDT_SHORT_US * `HSSP_CLK_MHZ,
	parameter WDT_LONG_CYCLES = `HSSP_WDT_LONG_US * `HSSP_CLK_MHZ,
	parameter FIFO_WIDTH = `HSSP_FIFO_WIDTH,
	parameter FIFO_DEPTH = `HSSP_FIFO_DEPTH
) (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Host pins
	input wire host_select_n_in,
	input wire host_serial_clock_line_in,
	input wire host_serial_data_in_in,
	output wire host_serial_data_in_out,
	output reg host_serial_data_in_oe_out,
	output wire host_serial_data_out_out,
	output reg host_serial_data_out_oe_out,
	// Command channel towards firmware
	output wire [FIFO_WIDTH-1:0] cmd_data_out,
	output wire cmd_valid_out,
	input wire cmd_ready_in,
	input wire [`HSSP_LEN_WIDTH-1:0] cmd_expect_len_in,
	output reg cmd_overflow_out,
	// Read channels from firmware
	output reg [1:0] rd_chan_out,
	input wire [7:0] rd_data_in,
	input wire rd_valid_in,
	output reg rd_pop_out,
	// Port state
	output reg serial_mode_out,
	output wire twi_busy_out,
	output wire twi_abort_out
);
	// ****************************************
	// Helpers
	// ****************************************
	// DMA channel addresses skip auto-increment
	function is_dma;
		input [6:0] a;
		begin
			is_dma = (a <= `HSSP_ADDR_STAT_CH);
		end
	endfunction

	function [6:0] step_addr;
		input [6:0] a;
		begin
			step_addr = is_dma(a) ? a : a + 7'h01;
		end
	endfunction

	// ****************************************
	// Reset and pin synchronisers
	// ****************************************
	reg rst_meta;
	reg rst_n;
	reg sel_m, sel_s, sel_d;
	reg sck_m, sck_s, sck_d;
	reg sdi_m, sdi_s;

	// Reset release through two flops
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Pins cross in two flops before any logic
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			sel_m <= 1'b1;
			sel_s <= 1'b1;
			sel_d <= 1'b1;
			sck_m <= 1'b1;
			sck_s <= 1'b1;
			sck_d <= 1'b1;
			sdi_m <= 1'b1;
			sdi_s <= 1'b1;
		end else begin
			sel_m <= host_select_n_in;
			sel_s <= sel_m;
			sel_d <= sel_s;
			sck_m <= host_serial_clock_line_in;
			sck_s <= sck_m;
			sck_d <= sck_s;
			sdi_m <= host_serial_data_in_in;
			sdi_s <= sdi_m;
		end
	end

	// oversampled, so bit rate is bounded by clock ratio
	wire sck_rise = sck_s & ~sck_d;
	wire sck_fall = ~sck_s & sck_d;
	wire sel_rise = sel_s & ~sel_d;

	// ****************************************
	// State
	// ****************************************
	reg [7:0] link_setup;
	reg ovf_flag;
	reg wdt_flag;
	reg [2:0] bit_cnt;
	reg [6:0] shin;
	reg addr_phase;
	reg is_read;
	reg [6:0] addr;
	reg [7:0] shout;
	reg sdo;
	reg pop_pend;
	reg [`HSSP_LEN_WIDTH-1:0] sess_cnt;
	reg sess_ovf;
	reg cmd_sess;
	reg push_q;
	reg [7:0] push_d;
	reg commit_q;
	reg discard_q;
	reg [7:0] mem [0:63];
	wire fifo_ready;
	wire twi_busy;
	wire twi_abort;
	wire active;
	wire three_wire;
	wire [7:0] byte_in;
	reg [7:0] rd_byte;

	assign three_wire = link_setup[`HSSP_LINK_THREE_WIRE];
	assign active = serial_mode_out & ~sel_s;
	assign byte_in = {shin, sdi_s};
	assign host_serial_data_in_out = sdo;
	assign host_serial_data_out_out = sdo;
	assign twi_busy_out = twi_busy;
	assign twi_abort_out = twi_abort;

	// ****************************************
	// Read data selection
	// ****************************************
	// Byte presented for the current read address
	always @* begin
		rd_byte = 8'h00;
		case (addr)
			`HSSP_ADDR_CMD_CH: rd_byte = 8'h00;
			`HSSP_ADDR_WAKE_CH,
			`HSSP_ADDR_NWAKE_CH,
			`HSSP_ADDR_STAT_CH: begin
				rd_byte = rd_valid_in ? rd_data_in : 8'h00;
			end
			`HSSP_ADDR_LINK_SETUP: rd_byte = link_setup;
			`HSSP_ADDR_PORT_STATUS: begin
				rd_byte = 8'h00;
				rd_byte[`HSSP_STAT_SERIAL] = serial_mode_out;
				rd_byte[`HSSP_STAT_OVERFLOW] = ovf_flag;
				rd_byte[`HSSP_STAT_TWI_BUSY] = twi_busy;
				rd_byte[`HSSP_STAT_WDT_ABORT] = wdt_flag;
			end
			default: begin
				if (addr <= `HSSP_ADDR_LAST) begin
					rd_byte = mem[addr[5:0]];
				end
			end
		endcase
	end

	// ****************************************
	// Register file storage
	// ****************************************
	// Plain registers; reserved ones store too, host must avoid them
	always @(posedge clk_in) begin
		if (active && sck_rise && bit_cnt == `HSSP_LAST_BIT &&
			~addr_phase && ~is_read && ~is_dma(addr) &&
			addr <= `HSSP_ADDR_LAST) begin
			mem[addr[5:0]] <= byte_in;
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************
	// Shifter, address decode and channel handling
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			serial_mode_out <= 1'b0;
			link_setup <= `HSSP_LINK_RESET;
			ovf_flag <= 1'b0;
			wdt_flag <= 1'b0;
			bit_cnt <= 3'h0;
			shin <= 7'h00;
			addr_phase <= 1'b1;
			is_read <= 1'b0;
			addr <= 7'h00;
			shout <= 8'h00;
			sdo <= 1'b0;
			pop_pend <= 1'b0;
			sess_cnt <= {`HSSP_LEN_WIDTH{1'b0}};
			sess_ovf <= 1'b0;
			cmd_sess <= 1'b0;
			push_q <= 1'b0;
			push_d <= 8'h00;
			commit_q <= 1'b0;
			discard_q <= 1'b0;
			cmd_overflow_out <= 1'b0;
			rd_chan_out <= 2'h0;
			rd_pop_out <= 1'b0;
			host_serial_data_in_oe_out <= 1'b0;
			host_serial_data_out_oe_out <= 1'b0;
		end else begin
			push_q <= 1'b0;
			commit_q <= 1'b0;
			discard_q <= 1'b0;
			rd_pop_out <= 1'b0;
			cmd_overflow_out <= 1'b0;
			// any select low locks serial mode
			if (~sel_s) begin
				serial_mode_out <= 1'b1;
			end
			if (twi_abort) begin
				wdt_flag <= 1'b1;
			end
			if (sel_s) begin
				bit_cnt <= 3'h0;
				addr_phase <= 1'b1;
				pop_pend <= 1'b0;
			end
			if (sel_rise && cmd_sess) begin
				cmd_sess <= 1'b0;
				sess_cnt <= {`HSSP_LEN_WIDTH{1'b0}};
				sess_ovf <= 1'b0;
				commit_q <= ~sess_ovf;
				discard_q <= sess_ovf;
				cmd_overflow_out <= sess_ovf;
				if (sess_ovf) begin
					ovf_flag <= 1'b1;
				end
			end
			if (active && sck_rise) begin
				shin <= byte_in[6:0];
				bit_cnt <= bit_cnt + 3'h1;
				if (pop_pend) begin
					rd_pop_out <= 1'b1;
					pop_pend <= 1'b0;
				end
				if (bit_cnt == `HSSP_LAST_BIT) begin
					if (addr_phase) begin
						addr_phase <= 1'b0;
						is_read <= byte_in[7];
						addr <= byte_in[6:0];
						rd_chan_out <= byte_in[1:0];
					end else if (~is_read) begin
						addr <= step_addr(addr);
						case (addr)
							`HSSP_ADDR_CMD_CH: begin
								cmd_sess <= 1'b1;
								if (fifo_ready && ~sess_ovf &&
									sess_cnt < cmd_expect_len_in) begin
									push_q <= 1'b1;
									push_d <= byte_in;
									sess_cnt <= sess_cnt +
										{{(`HSSP_LEN_WIDTH-1){1'b0}}, 1'b1};
								end else begin
									sess_ovf <= 1'b1;
								end
							end
							`HSSP_ADDR_LINK_SETUP: begin
								link_setup <= byte_in;
							end
							`HSSP_ADDR_PORT_STATUS: begin
								// Write one clears; a new event wins
								if (byte_in[`HSSP_STAT_OVERFLOW] &&
									~(sel_rise && cmd_sess && sess_ovf)) begin
									ovf_flag <= 1'b0;
								end
								if (byte_in[`HSSP_STAT_WDT_ABORT] &&
									~twi_abort) begin
									wdt_flag <= 1'b0;
								end
							end
							default: begin
							end
						endcase
					end
				end
			end
			// one read bit per falling edge
			if (active && sck_fall && ~addr_phase && is_read) begin
				if (bit_cnt == 3'h0) begin
					sdo <= rd_byte[7];
					shout <= {rd_byte[6:0], 1'b0};
					addr <= step_addr(addr);
					// Pop on the first rising edge of the byte, not on a trailing edge
					pop_pend <= is_dma(addr) &&
						(addr != `HSSP_ADDR_CMD_CH) && rd_valid_in;
				end else begin
					sdo <= shout[7];
					shout <= {shout[6:0], 1'b0};
				end
			end
			host_serial_data_out_oe_out <= active && ~addr_phase &&
				is_read && ~three_wire;
			// three-wire turns the data input around
			host_serial_data_in_oe_out <= active && ~addr_phase &&
				is_read && three_wire;
		end
	end

	// ****************************************
	// Command buffer
	// ****************************************
	// Full FIFO turns further bytes into an overflow
	hssp_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH),
		.AW($clog2(FIFO_DEPTH))
	) u_cmd_fifo (
		.clk_in(clk_in),
		.rstn_in(rst_n),
		.in_valid_in(push_q),
		.in_ready_out(fifo_ready),
		.in_data_in(push_d),
		.commit_in(commit_q),
		.discard_in(discard_q),
		.out_valid_out(cmd_valid_out),
		.out_ready_in(cmd_ready_in),
		.out_data_out(cmd_data_out)
	);

	// ****************************************
	// Two-wire stall watchdog
	// ****************************************
	// runs only while the two-wire engine owns the port
	hssp_twi_watchdog #(
		.SHORT_CYCLES(WDT_SHORT_CYCLES),
		.LONG_CYCLES(WDT_LONG_CYCLES)
	) u_wdt (
		.clk_in(clk_in),
		.rstn_in(rst_n),
		.scl_in(sck_s),
		.sda_in(sdi_s),
		.enable_in(link_setup[`HSSP_LINK_WDT_EN]),
		.long_in(link_setup[`HSSP_LINK_WDT_LONG]),
		.engine_on_in(~serial_mode_out),
		.busy_out(twi_busy),
		.abort_out(twi_abort)
	);
endmodule // hssp_top

// ---- verif/hssp_top_props.sv ----
// Port-level checker for the host serial slave port
`timescale 1ns/1ps
module hssp_top_props #(
	parameter FIFO_WIDTH = 8
) (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Host pins
	input wire host_select_n_in,
	input wire host_serial_clock_line_in,
	input wire host_serial_data_in_oe_out,
	input wire host_serial_data_out_out,
	input wire host_serial_data_out_oe_out,
	// Command channel
	input wire [FIFO_WIDTH-1:0] cmd_data_out,
	input wire cmd_valid_out,
	input wire cmd_ready_in,
	input wire cmd_overflow_out,
	// Port state
	input wire serial_mode_out,
	input wire twi_busy_out,
	input wire twi_abort_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_oe_exclusive: assert property (
		!(host_serial_data_in_oe_out && host_serial_data_out_oe_out))
		else $error("both data lines driven");
	a_oe_release: assert property (
		host_select_n_in [*6] |->
		!host_serial_data_in_oe_out && !host_serial_data_out_oe_out)
		else $error("data line driven while deselected");
	a_sdo_settled: assert property (
		(!host_select_n_in && host_serial_clock_line_in) [*6] |->
		$stable(host_serial_data_out_out))
		else $error("output data moved while clock high");
	a_mode_entry: assert property (
		$fell(host_select_n_in) |-> ##[2:6] serial_mode_out)
		else $error("select low did not enter serial mode");
	a_mode_sticky: assert property (
		serial_mode_out |=> serial_mode_out)
		else $error("serial mode left without reset");
	a_overflow_pulse: assert property (
		cmd_overflow_out |=> !cmd_overflow_out)
		else $error("overflow longer than one cycle");
	a_overflow_at_end: assert property (
		cmd_overflow_out |-> $past(host_select_n_in, 2))
		else $error("overflow reported inside a session");
	a_cmd_hold: assert property (
		cmd_valid_out && !cmd_ready_in |=>
		cmd_valid_out && $stable(cmd_data_out))
		else $error("command byte dropped while stalled");
	a_abort_busy: assert property (
		twi_abort_out |-> $past(twi_busy_out))
		else $error("abort without a transaction");

	c_overflow: cover property (cmd_overflow_out);
	c_three_wire: cover property (host_serial_data_in_oe_out);
	c_serial: cover property ($rose(serial_mode_out));
endmodule // hssp_top_props

bind hssp_top hssp_top_props #(.FIFO_WIDTH(FIFO_WIDTH)) i_props (
	.clk_in, .rstn_in, .host_select_n_in, .host_serial_clock_line_in,
	.host_serial_data_in_oe_out, .host_serial_data_out_out,
	.host_serial_data_out_oe_out, .cmd_data_out, .cmd_valid_out,
	.cmd_ready_in, .cmd_overflow_out, .serial_mode_out, .twi_busy_out,
	.twi_abort_out
);

// ---- verif/hssp_host_model.sv ----
// Host processor model acting as serial bus master
`timescale 1ns/1ps
module hssp_host_model (
	// Clock and mode
	input wire clk_in,
	input wire cpol_in,
	input wire three_in,
	// Pins
	output reg sel_n_out,
	output reg sclk_out,
	output wire sdi_out,
	input wire in_val_in,
	input wire in_oe_in,
	input wire out_val_in,
	input wire out_oe_in
);
	reg mosi = 1'b1;
	reg drive = 1'b1;
	initial begin
		sel_n_out = 1'b1;
		sclk_out = 1'b0;
	end
	// Released lines show the inverse, not a stale value
	assign sdi_out = in_oe_in ? in_val_in : (drive ? mosi : ~mosi);
	wire miso = three_in ? sdi_out : (out_oe_in ? out_val_in : ~mosi);

	task automatic hold(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// select falls with clock at idle level
	task automatic open_frame();
		sclk_out = cpol_in;
		hold(10);
		sel_n_out = 1'b0;
		hold(10);
	endtask
	// drive on fall, sample on rise, top bit first
	task automatic xfer(input [7:0] tx, input logic drv, output [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_out = 1'b0;
			drive = drv;
			mosi = tx[i];
			hold(10);
			sclk_out = 1'b1;
			rx[i] = miso;
			hold(10);
		end
	endtask
	task automatic close_frame();
		sclk_out = cpol_in;
		hold(10);
		sel_n_out = 1'b1;
		drive = 1'b1;
		// Data line idles at its pull-up level, no stale bit
		mosi = 1'b1;
		hold(10);
	endtask
endmodule // hssp_host_model

// ---- verif/hssp_top_tb.sv ----
// Self-checking testbench for the host serial slave port
`timescale 1ns/1ps
module hssp_top_tb;
	reg clk_in;
	reg rstn_in;
	reg cpol;
	reg three;
	reg stall = 1'b0;
	reg cmd_ready_in;
	reg [15:0] cmd_expect_len_in;
	reg [1:0] left [0:3] = '{2'd0, 2'd1, 2'd1, 2'd1};
	wire host_select_n_in, host_serial_clock_line_in, host_serial_data_in_in;
	wire host_serial_data_in_out, host_serial_data_in_oe_out;
	wire host_serial_data_out_out, host_serial_data_out_oe_out;
	wire cmd_valid_out, cmd_overflow_out, rd_pop_out, rd_valid_in;
	wire serial_mode_out, twi_busy_out, twi_abort_out;
	wire [7:0] cmd_data_out, rd_data_in;
	wire [1:0] rd_chan_out;
	int miscompares = 0;
	int checked = 0;
	int ovf_seen = 0;
	int abort_seen = 0;
	logic [7:0] rxq[$];
	logic [7:0] cmdq[$];

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	hssp_top #(.WDT_SHORT_CYCLES(50), .WDT_LONG_CYCLES(200)) i_dut (
		.clk_in, .rstn_in, .host_select_n_in, .host_serial_clock_line_in,
		.host_serial_data_in_in, .host_serial_data_in_out,
		.host_serial_data_in_oe_out, .host_serial_data_out_out,
		.host_serial_data_out_oe_out, .cmd_data_out, .cmd_valid_out,
		.cmd_ready_in, .cmd_expect_len_in, .cmd_overflow_out, .rd_chan_out,
		.rd_data_in, .rd_valid_in, .rd_pop_out, .serial_mode_out,
		.twi_busy_out, .twi_abort_out);

	hssp_host_model i_host (.clk_in, .cpol_in(cpol), .three_in(three),
		.sel_n_out(host_select_n_in), .sclk_out(host_serial_clock_line_in),
		.sdi_out(host_serial_data_in_in), .in_val_in(host_serial_data_in_out),
		.in_oe_in(host_serial_data_in_oe_out),
		.out_val_in(host_serial_data_out_out),
		.out_oe_in(host_serial_data_out_oe_out));

	// Firmware side: one byte per read channel, garbage when empty
	assign rd_valid_in = left[rd_chan_out] != 2'd0;
	assign rd_data_in = rd_valid_in ? {6'h18, rd_chan_out} : 8'hff;
	// Ready toggles; the first edge leaves the unknown start state
	always @(negedge clk_in) cmd_ready_in <= !stall && (cmd_ready_in !== 1'b1);
	always @(posedge clk_in) begin
		if (cmd_valid_out && cmd_ready_in) cmdq.push_back(cmd_data_out);
		if (rd_pop_out) left[rd_chan_out] <= left[rd_chan_out] - 2'd1;
		ovf_seen <= ovf_seen + cmd_overflow_out;
		abort_seen <= abort_seen + twi_abort_out;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk8(input string what, input [7:0] exp, input [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic frame(input [7:0] hdr, input logic [7:0] tx[$]);
		logic [7:0] r;
		rxq = {};
		i_host.open_frame();
		i_host.xfer(hdr, 1'b1, r);
		foreach (tx[i]) begin
			i_host.xfer(tx[i], !(three && hdr[7]), r);
			rxq.push_back(r);
		end
		i_host.close_frame();
	endtask
	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_twi();
		chk8("mode after reset", 8'h00, {7'h0, serial_mode_out});
		i_host.sclk_out = 1'b1;
		i_host.hold(10);
		i_host.mosi = 1'b0;
		i_host.hold(10);
		chk8("twi busy", 8'h01, {7'h0, twi_busy_out});
		i_host.hold(100);
		chk8("watchdog off", 8'h00, abort_seen[7:0]);
		i_host.mosi = 1'b1;
		i_host.hold(10);
		chk8("twi idle", 8'h00, {7'h0, twi_busy_out});
		$display("test twi done");
	endtask
	task automatic t_regs();
		logic [7:0] d;
		for (int m = 0; m < 2; m++) begin
			cpol = m[0];
			d = 8'ha5 + m[7:0];
			frame(8'h08, '{d, ~d});
			frame(8'h88, '{8'h00, 8'h00});
			chk8("burst first", d, rxq[0]);
			chk8("burst second", ~d, rxq[1]);
			frame(8'h89, '{8'h00});
			chk8("next register", ~d, rxq[0]);
		end
		frame(8'h96, '{8'h00, 8'h00});
		chk8("setup reset", 8'h00, rxq[0]);
		chk8("serial flag", 8'h01, rxq[1] & 8'h01);
		$display("test regs done");
	endtask
	task automatic t_three();
		frame(8'h16, '{8'h02});
		three = 1'b1;
		frame(8'h88, '{8'h00, 8'h00});
		chk8("three wire first", 8'ha6, rxq[0]);
		chk8("three wire second", 8'h59, rxq[1]);
		frame(8'h16, '{8'h00});
		three = 1'b0;
		frame(8'h96, '{8'h00});
		chk8("four wire back", 8'h00, rxq[0]);
		$display("test three done");
	endtask
	task automatic t_dma();
		for (int c = 1; c < 4; c++) begin
			frame({6'h20, c[1:0]}, '{8'h00, 8'h00});
			chk8("channel byte", {6'h18, c[1:0]}, rxq[0]);
			chk8("channel past end", 8'h00, rxq[1]);
			chk8("channel pops", 8'h00, {6'h0, left[c]});
		end
		frame(8'h80, '{8'h00});
		chk8("command read", 8'h00, rxq[0]);
		$display("test dma done");
	endtask
	task automatic t_cmd();
		int k;
		frame(8'h00, '{8'h11, 8'h22, 8'h33});
		for (k = 0; k < 200 && cmdq.size() < 3; k++) i_host.hold(1);
		if (k == 200) begin
			miscompares++;
			end_sim();
		end
		foreach (cmdq[i]) chk8("command byte", 8'h11 * (i + 1), cmdq[i]);
		cmdq = {};
		frame(8'h00, '{8'h44, 8'h55, 8'h66, 8'h77});
		i_host.hold(50);
		chk8("overflow long", 8'h01, ovf_seen[7:0]);
		stall = 1'b1;
		cmd_expect_len_in = 16'h0014;
		frame(8'h00, '{17{8'h5a}});
		stall = 1'b0;
		i_host.hold(50);
		chk8("overflow full", 8'h02, ovf_seen[7:0]);
		chk8("discarded", 8'h00, cmdq.size());
		frame(8'h97, '{8'h00});
		chk8("status overflow", 8'h03, rxq[0] & 8'h03);
		frame(8'h17, '{8'h02});
		frame(8'h97, '{8'h00});
		chk8("status cleared", 8'h01, rxq[0] & 8'h03);
		$display("test cmd done");
	endtask
	task automatic t_reset();
		frame(8'h16, '{8'h0c});
		rstn_in = 1'b0;
		i_host.hold(3);
		rstn_in = 1'b1;
		i_host.hold(5);
		chk8("mode after second reset", 8'h00, {7'h0, serial_mode_out});
		chk8("twi idle after reset", 8'h00, {7'h0, twi_busy_out});
		frame(8'h96, '{8'h00});
		chk8("setup after reset", 8'h00, rxq[0]);
		$display("test reset done");
	endtask

	initial begin
		#400000;
		miscompares++;
		end_sim();
	end
	initial begin
		rstn_in = 1'b0;
		cpol = 1'b0;
		three = 1'b0;
		cmd_expect_len_in = 16'h0003;
		repeat (10) @(negedge clk_in);
		rstn_in = 1'b1;
		repeat (5) @(negedge clk_in);
		t_twi();
		t_regs();
		t_three();
		t_dma();
		t_cmd();
		t_reset();
		end_sim();
	end
endmodule // hssp_top_tb
